// ### spa_top.sv
// Shared-pin multiplexer and alert logic of the receiver front end
`timescale 1ns/1ps
module spa_top #(
  parameter int ALARM_CYCLES = spa_pkg::ALARM_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cs_n_in,
  input wire logic sclk_alert_in,
  input wire logic data_pin_in,
  input wire logic [1:0] out_type,
  input wire logic filter_enable,
  input wire logic filter_pass,
  input wire logic demod_data,
  input wire logic carrier_in,
  input wire logic agc_init_done,
  input wire logic agc_settled,
  input wire logic inactivity_timeout,
  input wire logic parity_error,
  input wire logic spi_sdo,
  input wire logic spi_sdo_en,
  output logic alert_n_out,
  output logic alert_n_oe,
  output logic data_pin_out,
  output logic data_pin_oe,
  output logic spi_mode,
  output logic spi_sclk,
  output logic spi_sdi,
  output logic signal_strength_en,
  output logic alarm_expired
);
  logic [spa_pkg::SYNC_W-1:0] sync_q;
  logic cs_n_s;
  logic sclk_s;
  logic sdi_s;
  logic carrier_s;
  logic [spa_pkg::ALARM_W-1:0] alarm_cnt_reg;
  logic alarm_reg;
  logic alert_cond;
  logic recv_data;
  logic [spa_pkg::ALARM_W-1:0] chk_run_reg;

  // Local width copy keeps the size casts free of scoped names
  localparam int AW = spa_pkg::ALARM_W;
  localparam logic [spa_pkg::ALARM_W-1:0] ALARM_LAST = AW'(ALARM_CYCLES - 1);
  localparam logic [spa_pkg::ALARM_W-1:0] ALARM_FULL = AW'(ALARM_CYCLES);

  // Pin inputs and the analog carrier cross into core_clk
  spa_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d({carrier_in, data_pin_in, sclk_alert_in, cs_n_in}),
    .q(sync_q)
  );
  assign cs_n_s = sync_q[0];
  assign sclk_s = sync_q[1];
  assign sdi_s = sync_q[2];
  assign carrier_s = sync_q[3];

  // Alarm runs from AGC init end until the filter is passed
  always_ff @(posedge core_clk)
  begin
    if (rst || !agc_init_done || filter_pass)
    begin
      alarm_cnt_reg <= '0;
      alarm_reg <= 1'b0;
    end
    else if (alarm_cnt_reg == ALARM_LAST)
      alarm_reg <= 1'b1;
    else
      alarm_cnt_reg <= alarm_cnt_reg + 1'b1;
  end

  assign alert_cond = parity_error || alarm_reg;

  // Demod data gated by filter; inactivity pulse only with filter off
  always_comb
  begin
    if (filter_enable)
      recv_data = filter_pass && demod_data;
    else
      recv_data = demod_data || inactivity_timeout;
  end

  // Pin muxing by chip select; pull-ups keep both pins idle high
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      spi_mode <= 1'b0;
      alert_n_out <= 1'b0;
      alert_n_oe <= 1'b0;
      data_pin_out <= 1'b0;
      data_pin_oe <= 1'b0;
      spi_sclk <= spa_pkg::PIN_IDLE;
      spi_sdi <= 1'b0;
    end
    else
    begin
      spi_mode <= !cs_n_s;
      spi_sclk <= cs_n_s ? spa_pkg::PIN_IDLE : sclk_s;
      spi_sdi <= cs_n_s ? 1'b0 : sdi_s;
      // Open collector: drive low only, release otherwise
      alert_n_out <= 1'b0;
      alert_n_oe <= cs_n_s && alert_cond;
      if (!cs_n_s)
      begin
        data_pin_out <= spi_sdo;
        data_pin_oe <= spi_sdo_en;
      end
      else if (out_type == spa_pkg::OUT_CARRIER)
      begin
        // Square wave held low until AGC has settled
        data_pin_out <= agc_settled && carrier_s;
        data_pin_oe <= 1'b1;
      end
      else
      begin
        data_pin_out <= (out_type == spa_pkg::OUT_DEMOD) && recv_data;
        data_pin_oe <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      signal_strength_en <= 1'b0;
      alarm_expired <= 1'b0;
    end
    else
    begin
      signal_strength_en <= (out_type == spa_pkg::OUT_STRENGTH);
      alarm_expired <= alarm_reg;
    end
  end

  // Independent run length of the alarm condition, saturating at the limit
  always_ff @(posedge core_clk)
  begin
    if (rst || !agc_init_done || filter_pass)
      chk_run_reg <= '0;
    else if (chk_run_reg != ALARM_FULL)
      chk_run_reg <= chk_run_reg + 1'b1;
  end

  a_alert_low: assert property (@(posedge core_clk) disable iff (rst)
    (cs_n_s && alert_cond) |=> alert_n_oe && !alert_n_out)
    else $error("alert not driven low");
  a_alert_off_spi: assert property (@(posedge core_clk) disable iff (rst)
    !cs_n_s |=> !alert_n_oe)
    else $error("alert driven in spi mode");
  a_spi_mode: assert property (@(posedge core_clk) disable iff (rst)
    cs_n_s |=> !spi_mode)
    else $error("spi mode while select high");
  a_sdo_pass: assert property (@(posedge core_clk) disable iff (rst)
    !cs_n_s |=> data_pin_out == $past(spi_sdo) && data_pin_oe == $past(spi_sdo_en))
    else $error("serial data not routed");
  a_filter_block: assert property (@(posedge core_clk) disable iff (rst)
    (cs_n_s && filter_enable && !filter_pass && out_type == spa_pkg::OUT_DEMOD)
    |=> !data_pin_out)
    else $error("data escaped failed filter");
  a_inact_show: assert property (@(posedge core_clk) disable iff (rst)
    (cs_n_s && !filter_enable && inactivity_timeout && out_type == spa_pkg::OUT_DEMOD)
    |=> data_pin_out)
    else $error("inactivity timeout not shown");
  a_carrier_wait: assert property (@(posedge core_clk) disable iff (rst)
    (cs_n_s && !agc_settled && out_type == spa_pkg::OUT_CARRIER) |=> !data_pin_out)
    else $error("carrier before settle");
  a_strength_sel: assert property (@(posedge core_clk) disable iff (rst)
    ##1 signal_strength_en == ($past(out_type) == spa_pkg::OUT_STRENGTH))
    else $error("strength sink wrong");
  a_alarm_early: assert property (@(posedge core_clk) disable iff (rst)
    $rose(agc_init_done) && !filter_pass |=> !alarm_reg [*8])
    else $error("alarm too early");
  a_pin_mux: assert property (@(posedge core_clk) disable iff (rst)
    (cs_n_s && out_type != spa_pkg::OUT_STRENGTH) |=> data_pin_oe)
    else $error("data pin not driven in receive");
  a_mode_enter: assert property (@(posedge core_clk) disable iff (rst)
    !cs_n_s |=> spi_mode)
    else $error("spi mode missing while select low");
  a_sclk_route: assert property (@(posedge core_clk) disable iff (rst)
    !cs_n_s |=> spi_sclk == $past(sclk_s))
    else $error("serial clock not routed");
  a_sclk_idle: assert property (@(posedge core_clk) disable iff (rst)
    cs_n_s |=> spi_sclk)
    else $error("serial clock not idle in receive");
  a_sdi_route: assert property (@(posedge core_clk) disable iff (rst)
    !cs_n_s |=> spi_sdi == $past(sdi_s))
    else $error("serial input not routed");
  a_alert_release: assert property (@(posedge core_clk) disable iff (rst)
    (cs_n_s && !alert_cond) |=> !alert_n_oe)
    else $error("alert held without cause");
  a_alert_drive: assert property (@(posedge core_clk) disable iff (rst)
    !alert_n_out)
    else $error("open collector alert driven high");
  a_carrier_pass: assert property (@(posedge core_clk) disable iff (rst)
    (cs_n_s && agc_settled && out_type == spa_pkg::OUT_CARRIER)
    |=> data_pin_out == $past(carrier_s) && data_pin_oe)
    else $error("carrier not passed after settle");
  a_demod_pass: assert property (@(posedge core_clk) disable iff (rst)
    (cs_n_s && filter_enable && filter_pass && out_type == spa_pkg::OUT_DEMOD)
    |=> data_pin_out == $past(demod_data))
    else $error("demod data not passed after filter");
  a_inact_masked: assert property (@(posedge core_clk) disable iff (rst)
    (cs_n_s && filter_enable && !demod_data && inactivity_timeout
    && out_type == spa_pkg::OUT_DEMOD) |=> !data_pin_out)
    else $error("inactivity shown with filter on");
  a_alarm_count: assert property (@(posedge core_clk) disable iff (rst)
    alarm_reg == (chk_run_reg == ALARM_FULL))
    else $error("alarm count wrong");
  a_alarm_flag: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> alarm_expired == $past(alarm_reg))
    else $error("alarm flag does not follow timer");

  c_spi: cover property (@(posedge core_clk) disable iff (rst) $rose(spi_mode));
  c_alert: cover property (@(posedge core_clk) disable iff (rst) $rose(alert_n_oe));
  c_alarm: cover property (@(posedge core_clk) disable iff (rst) $rose(alarm_reg));
  c_carrier: cover property (@(posedge core_clk) disable iff (rst)
    cs_n_s && out_type == spa_pkg::OUT_CARRIER && data_pin_out);
endmodule

// ### spa_pkg.sv
// Package of constants for the shared-pin mode and alert block
package spa_pkg;
  // Output-type selection codes
  localparam logic [1:0] OUT_DEMOD = 2'h0;
  localparam logic [1:0] OUT_CARRIER = 2'h1;
  localparam logic [1:0] OUT_STRENGTH = 2'h2;
  // Clock rate and alarm timer
  localparam int CLK_MHZ = 250;
  localparam int ALARM_MS = 32;
  localparam int ALARM_CYCLES = ALARM_MS * 1000 * CLK_MHZ;
  localparam int ALARM_W = 24;
  localparam int SYNC_W = 4;
  // Reset values
  localparam logic PIN_IDLE = 1'b1;
endpackage

// ### spa_sync.sv
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module spa_sync (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [spa_pkg::SYNC_W-1:0] d,
  output logic [spa_pkg::SYNC_W-1:0] q
);
  logic [spa_pkg::SYNC_W-1:0] meta_reg;
  genvar i;
  generate
    for (i = 0; i < spa_pkg::SYNC_W; i++)
    begin : g_bit
      // Pins idle high through their pull-ups, so reset to high
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          meta_reg[i] <= spa_pkg::PIN_IDLE;
          q[i] <= spa_pkg::PIN_IDLE;
        end
        else
        begin
          meta_reg[i] <= d[i];
          q[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule

// ### spa_host.sv
// Host model driving the shared pins
`timescale 1ns/1ps
module spa_host (
  input wire logic core_clk,
  input wire logic sel,
  input wire logic sclk,
  input wire logic sdo,
  input wire logic alert_n_oe,
  input wire logic data_pin_out,
  input wire logic data_pin_oe,
  output logic cs_n_in,
  output logic sclk_alert_in,
  output logic data_pin_in
);
  logic junk_reg = 1'b0;
  always @(posedge core_clk) junk_reg <= ~junk_reg;
  assign cs_n_in = ~sel;
  assign sclk_alert_in = sel ? sclk : ~alert_n_oe;
  // Undriven line toggles so a stale value cannot pass
  assign data_pin_in = data_pin_oe ? data_pin_out : (sel ? sdo : junk_reg);
endmodule

// ### spa_top_tb.sv
// Testbench for the shared-pin block
`timescale 1ns/1ps
module spa_top_tb;
  logic core_clk = 1'b0, rst = 1'b1, sel = 1'b0, sclk = 1'b0, sdo = 1'b0, sdo_e = 1'b0;
  logic [1:0] out_type = 2'h0;
  logic fen = 1'b0, fpass = 1'b1, demod = 1'b0, carrier = 1'b1, agc_i = 1'b0;
  logic agc_s = 1'b1, inact = 1'b0, perr = 1'b0;
  logic cs_n, sa_pin, d_pin, a_out, a_oe, d_out, d_oe, mode, s_sclk, s_sdi, ss_en, alarm;
  int num_errors = 0, n_compared = 0;
  localparam int ALARM_N = 20;
  always #2 core_clk = ~core_clk;
  // Short alarm count keeps the run brief
  spa_top #(.ALARM_CYCLES(ALARM_N)) u_spa_top (.core_clk(core_clk), .rst(rst), .cs_n_in(cs_n),
    .sclk_alert_in(sa_pin), .data_pin_in(d_pin), .out_type(out_type), .filter_enable(fen),
    .filter_pass(fpass), .demod_data(demod), .carrier_in(carrier), .agc_init_done(agc_i),
    .agc_settled(agc_s), .inactivity_timeout(inact), .parity_error(perr), .spi_sdo(sdo),
    .spi_sdo_en(sdo_e), .alert_n_out(a_out), .alert_n_oe(a_oe), .data_pin_out(d_out),
    .data_pin_oe(d_oe), .spi_mode(mode), .spi_sclk(s_sclk), .spi_sdi(s_sdi),
    .signal_strength_en(ss_en), .alarm_expired(alarm));
  spa_host u_spa_host (.core_clk(core_clk), .sel(sel), .sclk(sclk), .sdo(sdo),
    .alert_n_oe(a_oe), .data_pin_out(d_out), .data_pin_oe(d_oe), .cs_n_in(cs_n),
    .sclk_alert_in(sa_pin), .data_pin_in(d_pin));
  task chk(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %b exp %b", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task summarize;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task t_spi;
    chk(s_sclk, 1'b1);
    sel = 1'b1;
    sclk = 1'b1;
    sdo = 1'b1;
    sdo_e = 1'b1;
    perr = 1'b1;
    cyc(4);
    chk(mode, 1'b1);
    chk(a_oe, 1'b0);
    chk(d_out & d_oe, 1'b1);
    sclk = 1'b0;
    sdo_e = 1'b0;
    cyc(4);
    chk(s_sclk, 1'b0);
    chk(d_oe, 1'b0);
    chk(s_sdi, 1'b1);
    sdo = 1'b0;
    cyc(4);
    chk(s_sdi, 1'b0);
    sel = 1'b0;
    cyc(4);
    chk(mode, 1'b0);
    chk(s_sclk, 1'b1);
    chk(a_oe | a_out, 1'b1);
    chk(a_out, 1'b0);
    perr = 1'b0;
    cyc(2);
    chk(a_oe, 1'b0);
  endtask
  task t_types;
    demod = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      out_type = i[1:0];
      cyc(4);
      chk(ss_en, i == 2);
      if (i != 2)
        chk(d_out, i < 2);
    end
    out_type = 2'h1;
    agc_s = 1'b0;
    cyc(4);
    chk(d_out, 1'b0);
    agc_s = 1'b1;
    cyc(2);
    chk(d_out, 1'b1);
    carrier = 1'b0;
    cyc(4);
    chk(d_out, 1'b0);
    out_type = 2'h0;
  endtask
  task t_filter;
    fen = 1'b1;
    fpass = 1'b0;
    cyc(2);
    chk(d_out, 1'b0);
    fen = 1'b0;
    demod = 1'b0;
    inact = 1'b1;
    cyc(2);
    chk(d_out, 1'b1);
    fen = 1'b1;
    agc_i = 1'b1;
    // Timer needs ALARM_N qualifying edges, then one output edge
    cyc(ALARM_N);
    chk(d_out | alarm, 1'b0);
    cyc(1);
    chk(alarm & a_oe, 1'b1);
    fpass = 1'b1;
    cyc(3);
    chk(alarm, 1'b0);
  endtask
  initial
  begin
    #3000;
    num_errors++;
    summarize;
  end
  initial
  begin
    cyc(3);
    rst = 1'b0;
    t_spi;
    t_types;
    t_filter;
    summarize;
  end
endmodule
